// ### flash_seq_pkg.sv
// Shared constants for the flash program/erase sequencer
`default_nettype none
package flash_seq_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_MODE_PRI  = 8'h00;
  localparam logic [7:0] OFF_MODE_SEC  = 8'h04;
  localparam logic [7:0] OFF_ERASE_SEL = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0c;
  localparam logic [7:0] OFF_RATE_SEL  = 8'h10;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_PROG   = 0;
  localparam int POS_ERASE  = 1;
  localparam int POS_PVER   = 2;
  localparam int POS_EVER   = 3;
  localparam int POS_SWE    = 6;
  localparam int POS_ERR    = 7;
  localparam int POS_PAGE_V = 0;
  localparam int POS_RATEOK = 1;
  localparam int POS_MODE   = 2;
  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int PAGE_BYTES = 128;
  localparam int IDX_W      = 7;
  localparam int ADDR_W     = 15;
  localparam int BLOCKS     = 5;
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;
  localparam logic [15:0] ERASED_WORD   = 16'hffff;
  localparam logic [7:0]  RST_MODE_PRI  = 8'h00;
  localparam logic [4:0]  RST_ERASE_SEL = 5'h00;
  localparam logic [2:0]  RST_RATE_SEL  = 3'h0;
  // ----------------------------------------
  // Auto-baud guaranteed ranges (kHz)
  // ----------------------------------------
  localparam int SLOW_MAX_KHZ = 10000;
  localparam int FAST_MAX_KHZ = 20000;
  localparam int MIN_1200_KHZ = 2000;
  localparam int MIN_2400_SLOW_KHZ = 4000;
  localparam int MIN_2400_FAST_KHZ = 2000;
  localparam int MIN_4800_SLOW_KHZ = 8000;
  localparam int MIN_4800_FAST_KHZ = 6000;
  localparam int MIN_9600_KHZ  = 8000;
  localparam int MIN_19200_KHZ = 16000;
  localparam logic [2:0] RATE_1200  = 3'h0;
  localparam logic [2:0] RATE_2400  = 3'h1;
  localparam logic [2:0] RATE_4800  = 3'h2;
  localparam logic [2:0] RATE_9600  = 3'h3;
  localparam logic [2:0] RATE_19200 = 3'h4;
  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [4:0] {
    MODE_IDLE  = 5'b00001,
    MODE_PROG  = 5'b00010,
    MODE_PVER  = 5'b00100,
    MODE_ERASE = 5'b01000,
    MODE_EVER  = 5'b10000
  } mode_t;
endpackage : flash_seq_pkg
`default_nettype wire

// ### page_latch.sv
// 128-byte program page latch held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module page_latch
  import flash_seq_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             clear,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [7:0]       wr_data,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [7:0]       rd_data
);
  logic [7:0] page_ff [PAGE_BYTES];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Unwritten bytes read as erased, so a short page programs nothing extra
  for (genvar i = 0; i < PAGE_BYTES; i++)
  begin : g_byte
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        page_ff[i] <= ERASED_BYTE;
      else if (ce && clear)
        page_ff[i] <= ERASED_BYTE;
      else if (ce && wr_en && (wr_idx == IDX_W'(i)))
        page_ff[i] <= wr_data;
    end
  end

  assign rd_data = page_ff[rd_idx];
endmodule : page_latch
`default_nettype wire

// ### flash_program_erase_sequencer.sv
// Flash program/erase sequencer: mode registers, page latch, verify and error protection
// ----------------------------------------
// Overview of operation
// - Array runs in program, program-verify, erase or erase-verify mode from primary control.
// - Device latches page address and 128 consecutive data bytes before the pulse.
// - Program pulse lasts exactly while the program bit is 1.
// - Verify: byte ff dummy-written to even address, then word read there.
// - Erase needs no prior pre-write to zeros.
// - Erase pulse lasts exactly while the erase bit is 1; here only while the program bit is also 0, since program wins.
// - Boot auto-baud is guaranteed only within the listed rate/clock ranges.
// - With write enable clear, program and erase bits are ignored.
// - Flash read, exception or sleep during a pulse sets error and aborts.
// ----------------------------------------
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_sequencer
  import flash_seq_pkg::*;
#(
  parameter int FOSC_KHZ     = 10000,
  parameter bit FAST_VARIANT = 1'b0
)
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  output logic      [7:0]        reg_rdata,
  input  wire logic [ADDR_W-1:0] fl_addr,
  input  wire logic [7:0]        fl_wdata,
  input  wire logic              fl_we,
  input  wire logic              fl_re,
  output logic      [15:0]       fl_rdata,
  input  wire logic              exception_evt,
  input  wire logic              sleep_evt,
  output logic                   arr_prog,
  output logic                   arr_erase,
  output logic      [BLOCKS-1:0] arr_blocks,
  output logic      [7:0]        arr_page_base,
  input  wire logic [IDX_W-1:0]  arr_byte_idx,
  output logic      [7:0]        arr_byte,
  output logic      [ADDR_W-1:0] arr_addr,
  input  wire logic [15:0]       arr_rdata
);
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic mode_t mode_of(input logic [7:0] mcr);
    if (mcr[POS_PROG])
      return MODE_PROG;
    else if (mcr[POS_ERASE])
      return MODE_ERASE;
    else if (mcr[POS_PVER])
      return MODE_PVER;
    else if (mcr[POS_EVER])
      return MODE_EVER;
    else
      return MODE_IDLE;
  endfunction : mode_of

  function automatic logic rate_ok(input logic [2:0] sel);
    int lo;
    int hi;
    lo = 0;
    hi = FAST_VARIANT ? FAST_MAX_KHZ : SLOW_MAX_KHZ;
    case (sel)
      RATE_1200:  lo = MIN_1200_KHZ;
      RATE_2400:  lo = FAST_VARIANT ? MIN_2400_FAST_KHZ : MIN_2400_SLOW_KHZ;
      RATE_4800:  lo = FAST_VARIANT ? MIN_4800_FAST_KHZ : MIN_4800_SLOW_KHZ;
      RATE_9600:  lo = FAST_VARIANT ? MIN_9600_KHZ : hi + 1;
      RATE_19200: lo = FAST_VARIANT ? MIN_19200_KHZ : hi + 1;
      default:    lo = hi + 1;
    endcase
    return (FOSC_KHZ >= lo) && (FOSC_KHZ <= hi);
  endfunction : rate_ok

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0]        mode_pri_ff;
  logic              err_ff;
  logic [BLOCKS-1:0] erase_sel_ff;
  logic [2:0]        rate_sel_ff;
  logic [7:0]        page_base_ff;
  logic              page_valid_ff;
  logic [ADDR_W-1:0] ver_addr_ff;
  logic [15:0]       fl_rdata_ff;
  logic [7:0]        reg_rdata_ff;

  mode_t             mode;
  logic              sel_pri;
  logic              sel_sec;
  logic              sel_ers;
  logic              sel_sts;
  logic              sel_rate;
  logic              wr_pri;
  logic              busy;
  logic              err_evt;
  logic              page_wr;
  logic              dummy_wr;
  logic [7:0]        nxt_mode_pri;
  logic [7:0]        rd_mux;

  assign sel_pri  = (reg_addr == OFF_MODE_PRI);
  assign sel_sec  = (reg_addr == OFF_MODE_SEC);
  assign sel_ers  = (reg_addr == OFF_ERASE_SEL);
  assign sel_sts  = (reg_addr == OFF_STATUS);
  assign sel_rate = (reg_addr == OFF_RATE_SEL);
  assign wr_pri   = reg_we && sel_pri;

  // Pulse bits only stick when write enable is set in the same write
  assign nxt_mode_pri = {1'b0, reg_wdata[POS_SWE], 2'b00,
                         reg_wdata[POS_EVER], reg_wdata[POS_PVER],
                         reg_wdata[POS_ERASE] & reg_wdata[POS_SWE],
                         reg_wdata[POS_PROG] & reg_wdata[POS_SWE]};

  assign mode     = mode_of(mode_pri_ff);
  assign busy     = (mode == MODE_PROG) || (mode == MODE_ERASE);
  assign err_evt  = busy && (fl_re || exception_evt || sleep_evt);
  assign page_wr  = fl_we && (mode == MODE_IDLE) && mode_pri_ff[POS_SWE];
  assign dummy_wr = fl_we && ((mode == MODE_PVER) || (mode == MODE_EVER))
                    && !fl_addr[0] && (fl_wdata == ERASED_BYTE);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_pri_ff  <= RST_MODE_PRI;
      erase_sel_ff <= RST_ERASE_SEL;
      rate_sel_ff  <= RST_RATE_SEL;
      err_ff       <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_pri)
        mode_pri_ff <= nxt_mode_pri;
      if (reg_we && sel_ers)
        erase_sel_ff <= reg_wdata[BLOCKS-1:0];
      if (reg_we && sel_rate)
        rate_sel_ff <= reg_wdata[2:0];
      // Sticky until reset; only a reset clears error protection
      if (err_evt)
        err_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Page address latch and verify address
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      page_base_ff  <= 8'h00;
      page_valid_ff <= 1'b0;
      ver_addr_ff   <= '0;
    end
    else if (ce)
    begin
      if (page_wr)
      begin
        page_base_ff  <= fl_addr[ADDR_W-1:IDX_W];
        page_valid_ff <= 1'b1;
      end
      else if (mode == MODE_PROG && wr_pri && !nxt_mode_pri[POS_PROG])
        page_valid_ff <= 1'b0;
      if (dummy_wr)
        ver_addr_ff <= fl_addr;
    end
  end

  page_latch u_page (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .clear    (ce && (mode == MODE_PROG) && wr_pri && !nxt_mode_pri[POS_PROG]),
    .wr_en    (page_wr),
    .wr_idx   (fl_addr[IDX_W-1:0]),
    .wr_data  (fl_wdata),
    .rd_idx   (arr_byte_idx),
    .rd_data  (arr_byte)
  );

  // ----------------------------------------
  // Array strobes
  // ----------------------------------------
  // Pulses follow the control bits directly; software owns the timing
  assign arr_prog      = (mode == MODE_PROG) && !err_ff;
  assign arr_erase     = (mode == MODE_ERASE) && !err_ff;
  assign arr_blocks    = erase_sel_ff;
  assign arr_page_base = page_base_ff;
  assign arr_addr      = ((mode == MODE_PVER) || (mode == MODE_EVER)) ? ver_addr_ff : fl_addr;

  // ----------------------------------------
  // Read paths
  // ----------------------------------------
  assign rd_mux = sel_pri  ? mode_pri_ff :
                  sel_sec  ? {err_ff, 7'h00} :
                  sel_ers  ? {3'h0, erase_sel_ff} :
                  sel_sts  ? {1'b0, mode, rate_ok(rate_sel_ff), page_valid_ff} :
                  sel_rate ? {5'h00, rate_sel_ff} : 8'h00;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata_ff <= 8'h00;
      fl_rdata_ff  <= ERASED_WORD;
    end
    else if (ce)
    begin
      if (reg_re)
        reg_rdata_ff <= rd_mux;
      // Array is not readable mid-pulse; return erased pattern instead
      if (fl_re)
        fl_rdata_ff <= busy ? ERASED_WORD : arr_rdata;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign fl_rdata  = fl_rdata_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  mode_onehot_a: assert property ($onehot(mode)
    && ((mode == MODE_PROG) == mode_pri_ff[POS_PROG])
    && ((mode == MODE_IDLE) == !(|mode_pri_ff[POS_EVER:POS_PROG])))
    else $error("mode decode wrong");
  page_base_a: assert property (ce && page_wr
    |=> arr_page_base == $past(fl_addr[ADDR_W-1:IDX_W]))
    else $error("page base not latched");
  prog_follow_a: assert property (arr_prog |-> mode_pri_ff[POS_PROG] && !err_ff)
    else $error("program pulse without bit");
  prog_start_a: assert property (ce && wr_pri && reg_wdata[POS_PROG]
    && reg_wdata[POS_SWE] && !err_ff && !err_evt |=> arr_prog)
    else $error("program pulse not started");
  erase_follow_a: assert property (arr_erase
    |-> mode_pri_ff[POS_ERASE] && !mode_pri_ff[POS_PROG])
    else $error("erase pulse without bit");
  verify_addr_a: assert property (ce && dummy_wr && !wr_pri
    |=> arr_addr == $past(fl_addr))
    else $error("verify address wrong");
  verify_read_a: assert property (ce && fl_re && !busy
    |=> fl_rdata == $past(arr_rdata))
    else $error("verify word not returned");
  swe_guard_a: assert property (ce && wr_pri && !reg_wdata[POS_SWE]
    |=> !arr_prog && !arr_erase)
    else $error("pulse without write enable");
  err_set_a: assert property (ce && err_evt |=> err_ff && !arr_prog && !arr_erase)
    else $error("error not flagged");
  err_hold_a: assert property (err_ff |=> err_ff)
    else $error("error flag dropped");
  erase_free_a: assert property (ce && wr_pri && reg_wdata[POS_ERASE]
    && reg_wdata[POS_SWE] && !reg_wdata[POS_PROG] && !err_ff && !err_evt |=> arr_erase)
    else $error("erase pulse not started");

  prog_cov: cover property (arr_prog ##1 !arr_prog);
  erase_cov: cover property (arr_erase ##[1:4] mode == MODE_EVER);
  err_cov: cover property (err_evt);
endmodule : flash_program_erase_sequencer
`default_nettype wire

// ### flash_program_erase_sequencer_tb.sv
// Self-checking testbench for the flash program/erase sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_sequencer_tb
  import flash_seq_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic              core_clk;
  logic              rst;
  logic              ce;
  logic [7:0]        reg_addr;
  logic [7:0]        reg_wdata;
  logic              reg_we;
  logic              reg_re;
  logic [7:0]        reg_rdata;
  logic [ADDR_W-1:0] fl_addr;
  logic [7:0]        fl_wdata;
  logic              fl_we;
  logic              fl_re;
  logic [15:0]       fl_rdata;
  logic              exception_evt;
  logic              sleep_evt;
  logic              arr_prog;
  logic              arr_erase;
  logic [BLOCKS-1:0] arr_blocks;
  logic [7:0]        arr_page_base;
  logic [IDX_W-1:0]  arr_byte_idx;
  logic [7:0]        arr_byte;
  logic [ADDR_W-1:0] arr_addr;
  logic [15:0]       arr_rdata;
  int                mismatches;
  int                cmp_count;
  int                i;
  int                k;
  // First-try pulse of 30 us at 25 ns per cycle
  localparam int     PULSE_30US = 1200;

  flash_program_erase_sequencer #(
    .FOSC_KHZ     (10000),
    .FAST_VARIANT (1'b0)
  ) u_dut (
    .core_clk      (core_clk),
    .rst           (rst),
    .ce            (ce),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_we        (reg_we),
    .reg_re        (reg_re),
    .reg_rdata     (reg_rdata),
    .fl_addr       (fl_addr),
    .fl_wdata      (fl_wdata),
    .fl_we         (fl_we),
    .fl_re         (fl_re),
    .fl_rdata      (fl_rdata),
    .exception_evt (exception_evt),
    .sleep_evt     (sleep_evt),
    .arr_prog      (arr_prog),
    .arr_erase     (arr_erase),
    .arr_blocks    (arr_blocks),
    .arr_page_base (arr_page_base),
    .arr_byte_idx  (arr_byte_idx),
    .arr_byte      (arr_byte),
    .arr_addr      (arr_addr),
    .arr_rdata     (arr_rdata)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic do_reset;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
  endtask : do_reset

  // Data is looked at 1 ns after the edge so the edge's updates have landed
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : reg_rd

  task automatic fl_acc(input logic we, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    fl_addr  <= a;
    fl_wdata <= d;
    fl_we    <= we;
    fl_re    <= !we;
    @(posedge core_clk);
    fl_we <= 1'b0;
    fl_re <= 1'b0;
    #1;
  endtask : fl_acc

  function automatic logic [7:0] stat(input mode_t m, input logic pl);
    return {1'b0, m, 1'b1, pl};
  endfunction : stat

  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    test_done();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1; ce = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00; reg_we = 1'b0;
    reg_re = 1'b0; fl_addr = '0; fl_wdata = 8'h00; fl_we = 1'b0; fl_re = 1'b0;
    exception_evt = 1'b0; sleep_evt = 1'b0; arr_byte_idx = '0; arr_rdata = 16'h1234;
    mismatches = 0; cmp_count = 0;
    do_reset();
    check({arr_prog, arr_erase, arr_blocks, arr_page_base}, 16'h0000);
    reg_rd(OFF_MODE_PRI, RST_MODE_PRI);
    reg_rd(OFF_MODE_SEC, 8'h00);
    reg_rd(OFF_STATUS, stat(MODE_IDLE, 1'b0));
    reg_rd(8'h20, 8'h00);
    // Slow variant at 10 MHz: 19200 is outside every range, 4800 inside
    reg_wr(OFF_RATE_SEL, {5'h00, RATE_19200});
    reg_rd(OFF_RATE_SEL, {5'h00, RATE_19200});
    reg_rd(OFF_STATUS, stat(MODE_IDLE, 1'b0) & 8'hfd);
    reg_wr(OFF_RATE_SEL, {5'h00, RATE_4800});
    reg_rd(OFF_STATUS, stat(MODE_IDLE, 1'b0));
    // Frozen clock enable must swallow the strobe
    @(posedge core_clk);
    ce <= 1'b0;
    reg_wr(OFF_MODE_PRI, 8'h40);
    @(posedge core_clk);
    ce <= 1'b1;
    reg_rd(OFF_MODE_PRI, 8'h00);
    reg_wr(OFF_MODE_PRI, 8'h01);
    check(arr_prog, 1'b0);
    reg_wr(OFF_MODE_PRI, 8'h02);
    check(arr_erase, 1'b0);
    reg_rd(OFF_MODE_PRI, 8'h00);
    // Full page, back to back, at the second page base (page 1, address 0x0080)
    reg_wr(OFF_MODE_PRI, 8'h40);
    for (i = 0; i < PAGE_BYTES; i++)
    begin
      @(posedge core_clk);
      fl_addr  <= 15'h0080 + 15'(i);
      fl_wdata <= 8'(i) ^ 8'h5a;
      fl_we    <= 1'b1;
    end
    @(posedge core_clk);
    fl_we <= 1'b0;
    #1;
    check(arr_page_base, 8'h01);
    for (i = 0; i < PAGE_BYTES; i++)
    begin
      @(posedge core_clk);
      arr_byte_idx <= 7'(i);
      #1;
      check(arr_byte, 8'(i) ^ 8'h5a);
    end
    reg_rd(OFF_STATUS, stat(MODE_IDLE, 1'b1));
    reg_wr(OFF_MODE_PRI, 8'h41);
    check(arr_prog, 1'b1);
    reg_rd(OFF_STATUS, stat(MODE_PROG, 1'b1));
    repeat (PULSE_30US) @(posedge core_clk);
    #1;
    check(arr_prog, 1'b1);
    reg_wr(OFF_MODE_PRI, 8'h40);
    check({arr_prog, arr_byte}, 9'h0ff);
    // Program-verify: dummy write then word read at the same even address
    reg_wr(OFF_MODE_PRI, 8'h44);
    fl_acc(1'b1, 15'h0100, 8'hff);
    check(arr_addr, 15'h0100);
    fl_acc(1'b0, 15'h0100, 8'h00);
    check(fl_rdata, 16'h1234);
    reg_rd(OFF_STATUS, stat(MODE_PVER, 1'b0));
    // Erase straight from the programmed state, no pre-write
    reg_wr(OFF_ERASE_SEL, 8'h01);
    reg_rd(OFF_ERASE_SEL, 8'h01);
    reg_wr(OFF_MODE_PRI, 8'h42);
    check({arr_erase, arr_blocks}, 6'h21);
    reg_rd(OFF_STATUS, stat(MODE_ERASE, 1'b0));
    reg_wr(OFF_MODE_PRI, 8'h40);
    check(arr_erase, 1'b0);
    reg_wr(OFF_MODE_PRI, 8'h48);
    reg_rd(OFF_STATUS, stat(MODE_EVER, 1'b0));
    @(posedge core_clk);
    arr_rdata <= 16'hc3a5;
    fl_acc(1'b1, 15'h0402, 8'hff);
    fl_acc(1'b0, 15'h0402, 8'h00);
    check(fl_rdata, 16'hc3a5);
    // Each abort cause in turn; the flag is sticky so reset between them
    for (k = 0; k < 3; k++)
    begin
      do_reset();
      reg_wr(OFF_ERASE_SEL, 8'h01);
      reg_wr(OFF_MODE_PRI, 8'h42);
      @(posedge core_clk);
      exception_evt <= (k == 0);
      sleep_evt     <= (k == 1);
      fl_re         <= (k == 2);
      fl_addr       <= 15'h0400;
      @(posedge core_clk);
      exception_evt <= 1'b0;
      sleep_evt     <= 1'b0;
      fl_re         <= 1'b0;
      #1;
      if (k == 2)
        check(fl_rdata, 16'hffff);
      repeat (2) @(posedge core_clk);
      #1;
      check(arr_erase, 1'b0);
      reg_rd(OFF_MODE_SEC, 8'h80);
      reg_rd(OFF_MODE_PRI, 8'h42);
      reg_wr(OFF_MODE_PRI, 8'h40);
      reg_wr(OFF_MODE_PRI, 8'h42);
      check(arr_erase, 1'b0);
      reg_wr(OFF_MODE_PRI, 8'h48);
      reg_rd(OFF_STATUS, stat(MODE_EVER, 1'b0));
    end
    test_done();
  end
endmodule : flash_program_erase_sequencer_tb
`default_nettype wire
